// *** hdl/hbs_bridge.sv ***
// one half-bridge static phase sequencer
`timescale 1ns/1ps
`include "hbs_params.svh"

module hbs_bridge #(
  parameter int CNT_W = 16
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic cmd_strobe,
  input wire logic charge_pump_enable,
  input wire logic bridge_pwm_select,
  input wire logic [1:0] bridge_mode_sel,
  input wire logic [CNT_W-1:0] cross_conduction_time,
  input wire logic [CNT_W-1:0] vds_blank_time,
  input wire logic [CNT_W-1:0] vds_filter_time,
  output hbs_pkg::hbs_phase_t phase,
  output logic [1:0] active_mode,
  output logic [CNT_W-1:0] count
);

  // ************************************************************
  // phase machine and interval counter
  // ************************************************************
  logic [CNT_W:0] charge_len;

  // blank and filter run back to back, so one load covers both
  assign charge_len = {1'b0, vds_blank_time} + {1'b0, vds_filter_time};

  // a new command restarts from the phase of the new target unless the pump is disabled, which wins
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      phase <= hbs_pkg::hbs_ph_passive;
      active_mode <= `HBS_MODE_PASSIVE;
      count <= `HBS_CNT_RESET;
    end else if (!charge_pump_enable) begin
      phase <= hbs_pkg::hbs_ph_passive;
      active_mode <= `HBS_MODE_PASSIVE;
      count <= `HBS_CNT_RESET;
    end else if (cmd_strobe) begin
      active_mode <= bridge_mode_sel;
      if (bridge_pwm_select) begin
        phase <= hbs_pkg::hbs_ph_pwm;
        count <= `HBS_CNT_RESET;
      end else if (bridge_mode_sel == `HBS_MODE_PASSIVE ||
                   bridge_mode_sel == `HBS_MODE_HOLD_OFF) begin
        // both-off targets discharge first; 00 then lets go, 11 then holds
        phase <= hbs_pkg::hbs_ph_ccp;
        count <= cross_conduction_time;
      end else if (active_mode == `HBS_MODE_HOLD_OFF) begin
        phase <= hbs_pkg::hbs_ph_charge; // no ccp from hold-off mode 11
        count <= charge_len[CNT_W-1:0];
      end else begin
        phase <= hbs_pkg::hbs_ph_ccp;
        count <= cross_conduction_time;
      end
    end else if (count != '0) begin
      count <= count - CNT_W'(1);
    end else begin
      // interval over: move on
      unique case (phase)
        hbs_pkg::hbs_ph_ccp: begin
          if (active_mode == `HBS_MODE_HOLD_OFF) begin
            phase <= hbs_pkg::hbs_ph_hold;
          end else if (active_mode == `HBS_MODE_PASSIVE) begin
            phase <= hbs_pkg::hbs_ph_passive;
          end else begin
            phase <= hbs_pkg::hbs_ph_charge;
            count <= charge_len[CNT_W-1:0];
          end
        end
        hbs_pkg::hbs_ph_charge: phase <= hbs_pkg::hbs_ph_hold;
        hbs_pkg::hbs_ph_passive, hbs_pkg::hbs_ph_hold, hbs_pkg::hbs_ph_pwm: phase <= phase;
        default: phase <= hbs_pkg::hbs_ph_passive;
      endcase
    end
  end

endmodule // hbs_bridge

// *** hdl/hbs_params.svh ***
// constants for the half-bridge static gate sequencer
`ifndef HBS_PARAMS_SVH
`define HBS_PARAMS_SVH

// bridge mode codes
`define HBS_MODE_PASSIVE 2'h0
`define HBS_MODE_LS_ON 2'h1
`define HBS_MODE_HS_ON 2'h2
`define HBS_MODE_HOLD_OFF 2'h3

// current step indices carried on the gate drive code
`define HBS_STEP_HOLD_LO 6'h13
`define HBS_STEP_HOLD_HI 6'h19

// synchroniser budget: command must take effect within this many ns
`define HBS_CLK_PERIOD_NS 5
`define HBS_CMD_DELAY_MAX_NS 3000
`define HBS_CMD_DELAY_CYCLES (`HBS_CMD_DELAY_MAX_NS / `HBS_CLK_PERIOD_NS)

// reset value of the interval counters
`define HBS_CNT_RESET 16'h0000

`endif

// *** hdl/hbs_pkg.sv ***
// types shared by the half-bridge static gate sequencer
package hbs_pkg;

  // drive kind applied to one gate
  typedef enum logic [2:0] {
    hbs_drv_passive,
    hbs_drv_source,
    hbs_drv_sink,
    hbs_drv_hardoff,
    hbs_drv_hold_on,
    hbs_drv_hold_off
  } hbs_drive_t;

  // phases of one bridge sequence
  typedef enum logic [2:0] {
    hbs_ph_passive,
    hbs_ph_ccp,
    hbs_ph_charge,
    hbs_ph_hold,
    hbs_ph_pwm
  } hbs_phase_t;

endpackage

// *** hdl/hbs_sequencer.sv ***
// four-bridge static gate sequencer top
// Behaviour
// - pump disabled: all gates passively off
// - mode 00: both gates passively off
// - mode 01: low on, high actively off
// - mode 10: high on, low actively off
// - mode 11: both held off at hold
// - pwm select 0 gives static activation
// - pwm select 1 skips static sequencing
// - four-bit static code per bridge
// - hold select 0 uses step 19
// - hold select 1 uses step 25
// - opposite gate gets maximum sink current
// - 01 to 10 passes cross-conduction interval
// - ccp: sink both gates with static code
// - then charge on-gate, hard-off other gate
// - after charge both gates go to hold
// - 11 to 10 skips cross-conduction interval
// - sync chip select, act within 3 us
// - four independent bridge sequencers
// - low-side turn-on mirrors high-side
// - both-off: static discharge, then hold-off
`timescale 1ns/1ps
`include "hbs_params.svh"

module hbs_sequencer #(
  parameter int NUM_BRIDGES = 4,
  parameter int CNT_W = 16
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic chip_select_n,
  input wire logic charge_pump_enable,
  input wire logic hold_current_sel,
  input wire logic [NUM_BRIDGES-1:0] bridge_pwm_select,
  input wire logic [2*NUM_BRIDGES-1:0] bridge_mode_sel,
  input wire logic [4*NUM_BRIDGES-1:0] static_drive_code,
  input wire logic [CNT_W-1:0] cross_conduction_time,
  input wire logic [CNT_W-1:0] vds_blank_time,
  input wire logic [CNT_W-1:0] vds_filter_time,
  output logic [3*NUM_BRIDGES-1:0] high_side_gate,
  output logic [3*NUM_BRIDGES-1:0] low_side_gate,
  output logic [6*NUM_BRIDGES-1:0] high_side_code,
  output logic [6*NUM_BRIDGES-1:0] low_side_code,
  output logic [NUM_BRIDGES-1:0] bridge_busy
);

  // ************************************************************
  // elaboration checks
  // ************************************************************
  // the bridge numbering and the mode register fix four bridges
  if (NUM_BRIDGES != 4) begin : g_bad_count
    $error("hbs_sequencer serves exactly four bridges");
  end
  if (CNT_W < 2 || CNT_W > 16) begin : g_bad_width
    $error("hbs_sequencer counter width must be 2 to 16");
  end

  // ************************************************************
  // chip select synchroniser
  // ************************************************************
  logic cs_meta;
  logic cs_sync;
  logic cs_last;
  logic cmd_strobe;

  // two flops, then an edge detect on the second only
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      cs_meta <= 1'b1;
      cs_sync <= 1'b1;
      cs_last <= 1'b1;
    end else begin
      cs_meta <= chip_select_n;
      cs_sync <= cs_meta;
      cs_last <= cs_sync;
    end
  end

  // rising edge reaches the bridges three cycles after the pin, far inside 3 us
  assign cmd_strobe = cs_sync && !cs_last;

  // ************************************************************
  // current step mapping
  // ************************************************************
  // static code n selects step 4n, a 6-bit step index
  function automatic logic [5:0] static_step(input logic [3:0] code);
    static_step = {code, 2'h0};
  endfunction

  // hold step follows the hold select bit
  function automatic logic [5:0] hold_step(input logic sel);
    hold_step = sel ? `HBS_STEP_HOLD_HI : `HBS_STEP_HOLD_LO;
  endfunction

  // step carried for a given drive kind; hard-off carries step 63, passive carries no step
  function automatic logic [5:0] drive_step(input hbs_pkg::hbs_drive_t kind,
                                            input logic [3:0] code, input logic sel);
    unique case (kind)
      hbs_pkg::hbs_drv_source, hbs_pkg::hbs_drv_sink: drive_step = static_step(code);
      hbs_pkg::hbs_drv_hold_on, hbs_pkg::hbs_drv_hold_off: drive_step = hold_step(sel);
      hbs_pkg::hbs_drv_hardoff: drive_step = 6'h3F;
      hbs_pkg::hbs_drv_passive: drive_step = 6'h00;
      default: drive_step = 6'h00;
    endcase
  endfunction

  // ************************************************************
  // per-bridge sequencers
  // ************************************************************
  hbs_pkg::hbs_phase_t phase [NUM_BRIDGES];
  logic [1:0] active_mode [NUM_BRIDGES];
  logic [CNT_W-1:0] count [NUM_BRIDGES];
  hbs_pkg::hbs_drive_t next_hs [NUM_BRIDGES];
  hbs_pkg::hbs_drive_t next_ls [NUM_BRIDGES];

  for (genvar b = 0; b < NUM_BRIDGES; b++) begin : g_bridge
    // each bridge decodes and sequences on its own
    hbs_bridge #(
      .CNT_W(CNT_W)
    ) u_bridge (
      .clock(clock),
      .rstn(rstn),
      .cmd_strobe(cmd_strobe),
      .charge_pump_enable(charge_pump_enable),
      .bridge_pwm_select(bridge_pwm_select[b]),
      .bridge_mode_sel(bridge_mode_sel[2*b+:2]),
      .cross_conduction_time(cross_conduction_time),
      .vds_blank_time(vds_blank_time),
      .vds_filter_time(vds_filter_time),
      .phase(phase[b]),
      .active_mode(active_mode[b]),
      .count(count[b])
    );

    // gate drive decode from phase and target mode
    always_comb begin
      next_hs[b] = hbs_pkg::hbs_drv_passive;
      next_ls[b] = hbs_pkg::hbs_drv_passive;
      unique case (phase[b])
        hbs_pkg::hbs_ph_passive, hbs_pkg::hbs_ph_pwm: begin
          // passive discharge; pwm drive is outside this block
          next_hs[b] = hbs_pkg::hbs_drv_passive;
          next_ls[b] = hbs_pkg::hbs_drv_passive;
        end
        hbs_pkg::hbs_ph_ccp: begin
          next_hs[b] = hbs_pkg::hbs_drv_sink;
          next_ls[b] = hbs_pkg::hbs_drv_sink;
        end
        hbs_pkg::hbs_ph_charge: begin
          // low-side turn-on swaps the roles
          if (active_mode[b] == `HBS_MODE_LS_ON) begin
            next_hs[b] = hbs_pkg::hbs_drv_hardoff;
            next_ls[b] = hbs_pkg::hbs_drv_source;
          end else begin
            next_hs[b] = hbs_pkg::hbs_drv_source;
            next_ls[b] = hbs_pkg::hbs_drv_hardoff;
          end
        end
        hbs_pkg::hbs_ph_hold: begin
          if (active_mode[b] == `HBS_MODE_LS_ON) begin
            next_hs[b] = hbs_pkg::hbs_drv_hold_off;
            next_ls[b] = hbs_pkg::hbs_drv_hold_on;
          end else if (active_mode[b] == `HBS_MODE_HS_ON) begin
            next_hs[b] = hbs_pkg::hbs_drv_hold_on;
            next_ls[b] = hbs_pkg::hbs_drv_hold_off;
          end else begin
            next_hs[b] = hbs_pkg::hbs_drv_hold_off;
            next_ls[b] = hbs_pkg::hbs_drv_hold_off;
          end
        end
        default: begin
          next_hs[b] = hbs_pkg::hbs_drv_passive;
          next_ls[b] = hbs_pkg::hbs_drv_passive;
        end
      endcase
    end

    // ************************************************************
    // registered outputs
    // ************************************************************
    // outputs registered so gate drivers never see decode glitches
    always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
        high_side_gate[3*b+:3] <= 3'h0;
        low_side_gate[3*b+:3] <= 3'h0;
        high_side_code[6*b+:6] <= 6'h00;
        low_side_code[6*b+:6] <= 6'h00;
        bridge_busy[b] <= 1'b0;
      end else begin
        high_side_gate[3*b+:3] <= next_hs[b];
        low_side_gate[3*b+:3] <= next_ls[b];
        high_side_code[6*b+:6] <= drive_step(next_hs[b], static_drive_code[4*b+:4],
                                             hold_current_sel);
        low_side_code[6*b+:6] <= drive_step(next_ls[b], static_drive_code[4*b+:4],
                                            hold_current_sel);
        bridge_busy[b] <= (phase[b] == hbs_pkg::hbs_ph_ccp) ||
                          (phase[b] == hbs_pkg::hbs_ph_charge);
      end
    end
  end

endmodule // hbs_sequencer

// *** tb/hbs_host.sv ***
// host model: frames one command on chip select when asked
`timescale 1ns/1ps
module hbs_host (
  input wire logic clock,
  input wire logic go,
  output logic chip_select_n
);
  logic [1:0] cnt = 2'h0;
  // select held low four cycles; the rising edge commits the command
  // changes land just after the edge so the device never samples a moving pin
  always @(posedge clock) begin
    if (go) cnt <= #1 2'h3;
    else if (cnt != 2'h0) cnt <= #1 cnt - 2'h1;
    chip_select_n <= #1 !(go || cnt != 2'h0);
  end
  initial chip_select_n = 1'b1;
endmodule  // hbs_host

// *** tb/hbs_sequencer_chk.sv ***
// concurrent checks on the ports of the four-bridge sequencer
`timescale 1ns/1ps
module hbs_sequencer_chk #(
  parameter int NUM_BRIDGES = 4,
  parameter int CNT_W = 16
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic chip_select_n,
  input wire logic charge_pump_enable,
  input wire logic hold_current_sel,
  input wire logic [NUM_BRIDGES-1:0] bridge_pwm_select,
  input wire logic [4*NUM_BRIDGES-1:0] static_drive_code,
  input wire logic [3*NUM_BRIDGES-1:0] high_side_gate,
  input wire logic [3*NUM_BRIDGES-1:0] low_side_gate,
  input wire logic [6*NUM_BRIDGES-1:0] high_side_code,
  input wire logic [6*NUM_BRIDGES-1:0] low_side_code,
  input wire logic [NUM_BRIDGES-1:0] bridge_busy
);
  // ***
  // bridge 0 relations; the pump-off check covers all four bridges
  // ***
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  // phase drops one edge after the pump bit, the registered gates one edge later
  pump_off_a: assert property (!charge_pump_enable |=> ##1
    high_side_gate == '0 && low_side_gate == '0) else $error("gate live with pump off");
  passive_code_a: assert property (high_side_gate[2:0] == 3'h0 |->
    high_side_code[5:0] == 6'h00) else $error("passive gate carries a step");
  sink_code_a: assert property (high_side_gate[2:0] == 3'h2 |->
    high_side_code[5:0] == {$past(static_drive_code[3:0]), 2'b00}) else $error("sink step");
  hard_off_a: assert property (low_side_gate[2:0] == 3'h3 |->
    low_side_code[5:0] == 6'h3F) else $error("hard off step");
  charge_pair_a: assert property (high_side_gate[2:0] == 3'h1 |->
    low_side_gate[2:0] == 3'h3) else $error("high charge without low hard off");
  mirror_pair_a: assert property (low_side_gate[2:0] == 3'h1 |->
    high_side_gate[2:0] == 3'h3) else $error("low charge without high hard off");
  hold_code_a: assert property (high_side_gate[2:0] inside {3'h4, 3'h5} |->
    high_side_code[5:0] == ($past(hold_current_sel) ? 6'h19 : 6'h13)) else $error("hold step");
  cmd_start_a: assert property ($rose(chip_select_n) && charge_pump_enable &&
    !bridge_pwm_select[0] |-> ##[1:8] bridge_busy[0]) else $error("command not started");
  seq_end_a: assert property ($fell(bridge_busy[0]) && charge_pump_enable |->
    !(high_side_gate[2:0] inside {3'h1, 3'h2, 3'h3})) else $error("drive left after end");
endmodule  // hbs_sequencer_chk

bind hbs_sequencer hbs_sequencer_chk #(.NUM_BRIDGES(NUM_BRIDGES), .CNT_W(CNT_W))
  hbs_sequencer_chk_inst (.clock, .rstn, .chip_select_n, .charge_pump_enable,
  .hold_current_sel, .bridge_pwm_select, .static_drive_code, .high_side_gate,
  .low_side_gate, .high_side_code, .low_side_code, .bridge_busy);

// *** tb/hbs_sequencer_tb_top.sv ***
// self-checking bench for the four-bridge static gate sequencer
`timescale 1ns/1ps
module hbs_sequencer_tb_top;
  logic clock, go = 1'b0, rstn = 1'b0, chip_select_n;
  logic charge_pump_enable = 1'b1, hold_current_sel = 1'b0;
  logic [3:0] bridge_pwm_select = 4'h0, bridge_busy;
  logic [7:0] bridge_mode_sel = 8'h0C;  // bridge 1 parked in mode 11
  logic [15:0] static_drive_code = 16'h0005;
  // short intervals: ccp four cycles, charge four cycles
  logic [15:0] cross_conduction_time = 16'h0003;
  logic [15:0] vds_blank_time = 16'h0002, vds_filter_time = 16'h0001;
  logic [11:0] high_side_gate, low_side_gate;
  logic [23:0] high_side_code, low_side_code;
  int n_fail = 0, num_checks = 0;
  // ***
  // harness
  // ***
  hbs_host hbs_host_inst (.clock, .go, .chip_select_n);
  hbs_sequencer hbs_sequencer_inst (.clock, .rstn, .chip_select_n, .charge_pump_enable,
    .hold_current_sel, .bridge_pwm_select, .bridge_mode_sel, .static_drive_code,
    .cross_conduction_time, .vds_blank_time, .vds_filter_time, .high_side_gate,
    .low_side_gate, .high_side_code, .low_side_code, .bridge_busy);
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  task automatic chk(input logic [5:0] got, input logic [5:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // one command on bridge 0; counts cycles of sink, source and hard-off drive, then the settled state
  task automatic cmd(input string nm, input logic [1:0] m, input logic [5:0] e_hk, e_lk,
      e_src, e_hd, input logic [2:0] e_h, e_l, input logic [5:0] e_c);
    logic [5:0] hk, lk, src, hd, bsy;
    bsy = 6'h00;
    hk = 6'h00;
    lk = 6'h00;
    src = 6'h00;
    hd = 6'h00;
    bridge_mode_sel[1:0] = m;
    go = 1'b1;
    @(posedge clock) #1 go = 1'b0;
    repeat (30) begin
      @(posedge clock) #1;
      hk += {5'h00, high_side_gate[2:0] === 3'h2};
      lk += {5'h00, low_side_gate[2:0] === 3'h2};
      src += {5'h00, high_side_gate[2:0] === 3'h1 || low_side_gate[2:0] === 3'h1};
      hd += {5'h00, high_side_gate[2:0] === 3'h3 || low_side_gate[2:0] === 3'h3};
      bsy += {5'h00, bridge_busy[0] === 1'b1};
    end
    chk(hk, e_hk);
    chk(lk, e_lk);
    chk(src, e_src);
    chk(hd, e_hd);
    chk(bsy, e_hk + e_src);
    chk({3'h0, high_side_gate[2:0]}, {3'h0, e_h});
    chk({3'h0, low_side_gate[2:0]}, {3'h0, e_l});
    chk(high_side_code[5:0], e_c);
    chk(low_side_code[5:0], e_c);
    $display("%s done", nm);
  endtask
  // ***
  // scenarios
  // ***
  task automatic s_low();  // low side on from passive: ccp first
    cmd("low on", 2'h1, 6'd4, 6'd4, 6'd4, 6'd4, 3'h5, 3'h4, 6'h13);
  endtask
  task automatic s_ccp();  // low to high with the largest drive code
    static_drive_code = 16'h000F;
    cmd("ccp", 2'h2, 6'd4, 6'd4, 6'd4, 6'd4, 3'h4, 3'h5, 6'h13);
    chk({3'h0, high_side_gate[5:3]}, 6'h05);
  endtask
  task automatic s_both();  // both off through static discharge
    static_drive_code = 16'h0000;
    cmd("both off", 2'h3, 6'd4, 6'd4, 6'd0, 6'd0, 3'h5, 3'h5, 6'h13);
  endtask
  task automatic s_skip();  // from both off: no ccp, hold step 25
    hold_current_sel = 1'b1;
    cmd("skip", 2'h2, 6'd0, 6'd0, 6'd4, 6'd4, 3'h4, 3'h5, 6'h19);
  endtask
  task automatic s_pass();  // passive off after discharge
    cmd("passive", 2'h0, 6'd4, 6'd4, 6'd0, 6'd0, 3'h0, 3'h0, 6'h00);
  endtask
  task automatic s_pwm();  // pwm bridge gets no static sequence
    bridge_pwm_select = 4'h1;
    cmd("pwm", 2'h2, 6'd0, 6'd0, 6'd0, 6'd0, 3'h0, 3'h0, 6'h00);
    bridge_pwm_select = 4'h0;
  endtask
  task automatic s_off();  // pump off refuses every bridge
    charge_pump_enable = 1'b0;
    cmd("pump off", 2'h2, 6'd0, 6'd0, 6'd0, 6'd0, 3'h0, 3'h0, 6'h00);
    chk({3'h0, high_side_gate[5:3]}, 6'h00);
  endtask
  initial begin
    repeat (10) @(posedge clock);
    #1 rstn = 1'b1;
    s_low();
    s_ccp();
    s_both();
    s_skip();
    s_pass();
    s_pwm();
    s_off();
    stop_test();
  end
  // watchdog: seven commands need about 250 cycles
  initial begin
    #20000;
    n_fail++;
    stop_test();
  end
endmodule  // hbs_sequencer_tb_top
